// ==== design/rtos_defines.svh ====
// Offsets, field positions, reset values and timing counts for output select
`ifndef RTOS_DEFINES_SVH
`define RTOS_DEFINES_SVH
`define RTOS_ADDR_W 4
`define RTOS_OFS_OVR 4'h0
`define RTOS_OFS_MUX 4'h1
`define RTOS_OFS_SD 4'h2
`define RTOS_OFS_DIV 4'h3
`define RTOS_OFS_STAT 4'h4
`define RTOS_OFS_QCLK 4'h5
`define RTOS_OVR_MUX_BIT 5
`define RTOS_OVR_DIV_BIT 2
`define RTOS_OVR_RAWOK_BIT 7
`define RTOS_MUX_LSB 5
`define RTOS_SD_FORCE_BIT 7
`define RTOS_SD_KILL_BIT 6
`define RTOS_DIV_LSB 4
`define RTOS_OVR_RST 8'h00
`define RTOS_MUX_RST 3'h7
`define RTOS_DIV_RST 3'h0
`define RTOS_DIV_MAX 3'h4
`define RTOS_CLK_HZ 125000000
`define RTOS_REF_HZ 10000000
`define RTOS_REF_HALF ((`RTOS_CLK_HZ / `RTOS_REF_HZ) / 2)
`endif

// ==== design/rtos_pkg.sv ====
// Types shared by the output select block
`default_nettype none
package rtos_pkg;
  typedef enum logic [2:0] {
    RTOS_SRC_RAW = 3'h0,
    RTOS_SRC_RETIMED = 3'h1,
    RTOS_SRC_ICLK = 3'h2,
    RTOS_SRC_QCLK = 3'h3,
    RTOS_SRC_PATTERN = 3'h4,
    RTOS_SRC_REFCLK = 3'h5,
    RTOS_SRC_INVALID = 3'h6,
    RTOS_SRC_MUTE = 3'h7
  } rtos_src_t;
  typedef enum {RTOS_IDLE, RTOS_ACK} rtos_bus_state_t;
endpackage
`default_nettype wire

// ==== design/rtos_osc.sv ====
// Free-running internal reference clock divider
`default_nettype none
`include "rtos_defines.svh"
module rtos_osc #(
  parameter int HALF = `RTOS_REF_HALF
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst_n, // Async reset
  input wire logic i_ce, // Clock enable
  output logic o_ref // Free-running reference
);
  localparam int CW = (HALF < 2) ? 1 : $clog2(HALF);
  logic [CW-1:0] cnt;
  initial
  begin
    if (HALF < 1) $error("HALF must be at least one");
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt <= '0;
      o_ref <= 1'b0;
    end
    else if (i_ce)
    begin
      if (cnt == CW'(HALF - 1))
      begin
        cnt <= '0;
        o_ref <= ~o_ref;
      end
      else
        cnt <= cnt + 1'b1;
    end
  end
endmodule // rtos_osc
`default_nettype wire

// ==== design/rtos_divsel.sv ====
// VCO divide ratio selection with override
`default_nettype none
`include "rtos_defines.svh"
module rtos_divsel (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst_n, // Async reset
  input wire logic i_ce, // Clock enable
  input wire logic i_ovr_en, // Divider override enable
  input wire logic [2:0] i_ovr_code, // Programmed divider code
  input wire logic [2:0] i_auto_code, // Automatic divider code
  output logic [2:0] o_code, // Applied divider code
  output logic [4:0] o_ratio // Applied ratio, one-hot 1..16
);
  wire auto_ok = i_auto_code <= `RTOS_DIV_MAX;
  wire ovr_ok = i_ovr_code <= `RTOS_DIV_MAX;
  // Invalid codes keep the previous divider
  wire take = i_ovr_en ? ovr_ok : auto_ok;
  wire [2:0] next_code = i_ovr_en ? i_ovr_code : i_auto_code;
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_code <= `RTOS_DIV_RST;
    else if (i_ce && take)
      o_code <= next_code;
  end
  assign o_ratio = 5'(5'h01 << o_code);
endmodule // rtos_divsel
`default_nettype wire

// ==== design/rtos_top.sv ====
// Per-channel output source select and VCO divider override
// Notes on behaviour
// - No overrides: mute without signal or lock, retimed data once locked; here unlocked with signal applies the selector (reset 7, mute).
// - Selector 7 mute,6 invalid,5 clock,4 pattern,3 Q,2 I,1 retimed,0 raw.
// - Override clear: selector applies only while signal present but unlocked.
// - Override set: selector drives output regardless of lock state; here selector 3 (Q) is muted unless the Q clock register holds 3.
// - Raw output needs override plus re-search disable; then never muted.
// - No signal detected powers down the channel and mutes output.
// - Force bit set, kill bit clear forces signal detect on.
// - Both signal detect bits clear resumes automatic detection.
// - Forced on without signal, data sources pass noise through.
// - Pattern runs at free-run rate, or input rate when locked.
// - Internal clock selectable under override, free-running, unsynchronised.
// - When locked, VCO clocks and pattern follow the input.
// - Automatic divide ratio from bit rate: 1,2,4,8,16.
// - Divider override enable takes ratio from divider field.
// - Divider field 0..4 maps to ratios 1,2,4,8,16.
// - Override register resets to zero; writing zero clears overrides.
//
// Chosen here: the register offsets and register access over Avalon-MM.
`default_nettype none
`include "rtos_defines.svh"
module rtos_top
(
  input wire logic i_clk_sys, // System clock 125 MHz
  input wire logic i_rst_n, // Async reset
  input wire logic i_ce, // Clock enable
  input wire logic [`RTOS_ADDR_W-1:0] i_avs_address, // Word address
  input wire logic i_avs_read, // Read strobe
  input wire logic i_avs_write, // Write strobe
  input wire logic [31:0] i_avs_writedata, // Write data
  input wire logic [3:0] i_avs_byteenable, // Byte enables
  output logic [31:0] o_avs_readdata, // Read data
  output logic o_avs_waitrequest, // Wait request
  output logic [1:0] o_avs_response, // Response code
  input wire logic i_sig_det, // Raw signal detect
  input wire logic i_locked, // CDR lock
  input wire logic i_raw_data, // Equalised unretimed data
  input wire logic i_retimed_data, // Retimed data
  input wire logic i_vco_iclk, // VCO in-phase clock
  input wire logic i_vco_qclk, // VCO quadrature clock
  input wire logic i_pattern, // Pattern generator bit
  input wire logic [2:0] i_auto_div, // Automatic divider code
  output logic o_data, // Channel output
  output logic o_drv_en, // Output driver enable
  output logic o_chan_pwr, // Channel power enable
  output var rtos_pkg::rtos_src_t o_src, // Applied source
  output logic [2:0] o_div_code, // Applied divider code
  output logic [4:0] o_div_ratio // Applied divider ratio
);
  import rtos_pkg::*;

  logic [7:0] ovr_reg;
  logic [2:0] mux_sel;
  logic [1:0] sd_ctl;
  logic [2:0] div_field;
  logic [1:0] qclk_en;
  rtos_bus_state_t bus_state;
  logic ref_clk;

  // Register decode
  wire hit_ovr = i_avs_address == `RTOS_OFS_OVR;
  wire hit_mux = i_avs_address == `RTOS_OFS_MUX;
  wire hit_sd = i_avs_address == `RTOS_OFS_SD;
  wire hit_div = i_avs_address == `RTOS_OFS_DIV;
  wire hit_stat = i_avs_address == `RTOS_OFS_STAT;
  wire hit_qclk = i_avs_address == `RTOS_OFS_QCLK;
  wire mapped = hit_ovr | hit_mux | hit_sd | hit_div | hit_stat | hit_qclk;
  wire req = i_avs_read | i_avs_write;
  wire acc = req && bus_state == RTOS_ACK && i_ce;
  wire wr0 = acc && i_avs_write && i_avs_byteenable[0];

  // Control bits
  wire mux_ovr = ovr_reg[`RTOS_OVR_MUX_BIT];
  wire div_ovr = ovr_reg[`RTOS_OVR_DIV_BIT];
  wire raw_hold = ovr_reg[`RTOS_OVR_RAWOK_BIT];
  wire sd_force = sd_ctl == 2'b10;
  wire sd_auto = sd_ctl == 2'b00;
  wire sd_kill = sd_ctl[0] & ~sd_ctl[1];
  wire sig_ok = sd_force | (sd_auto & i_sig_det) | ((sd_ctl == 2'b11)
    & i_sig_det);

  // Source selection
  wire rtos_src_t sel_src = rtos_src_t'(mux_sel);
  wire rtos_src_t auto_src = !sig_ok ? RTOS_SRC_MUTE
    : i_locked ? RTOS_SRC_RETIMED
    : sel_src;
  wire rtos_src_t pick_src = mux_ovr ? sel_src : auto_src;
  // Raw data in override bypasses power-down only with re-search held off
  wire raw_bypass = mux_ovr && sel_src == RTOS_SRC_RAW && raw_hold;
  wire pwr_on = (sig_ok & ~sd_kill) | raw_bypass;
  wire rtos_src_t next_src = !pwr_on ? RTOS_SRC_MUTE
    : (pick_src == RTOS_SRC_INVALID) ? RTOS_SRC_MUTE
    : (pick_src == RTOS_SRC_QCLK && qclk_en != 2'b11) ? RTOS_SRC_MUTE
    : pick_src;

  function automatic logic src_bit(input rtos_src_t s);
    unique case (s)
      RTOS_SRC_RAW: src_bit = i_raw_data;
      RTOS_SRC_RETIMED: src_bit = i_retimed_data;
      RTOS_SRC_ICLK: src_bit = i_vco_iclk;
      RTOS_SRC_QCLK: src_bit = i_vco_qclk;
      RTOS_SRC_PATTERN: src_bit = i_pattern;
      RTOS_SRC_REFCLK: src_bit = ref_clk;
      RTOS_SRC_INVALID: src_bit = 1'b0;
      RTOS_SRC_MUTE: src_bit = 1'b0;
    endcase
  endfunction

  wire next_data = src_bit(next_src);
  wire [7:0] stat_val = {1'b0, pwr_on, i_locked, sig_ok, 1'b0, o_src};
  wire [7:0] rd_val = hit_ovr ? ovr_reg
    : hit_mux ? {mux_sel, 5'h00}
    : hit_sd ? {sd_ctl, 6'h00}
    : hit_div ? {1'b0, div_field, 4'h0}
    : hit_stat ? stat_val
    : hit_qclk ? {6'h00, qclk_en}
    : 8'h00;

  rtos_osc u_osc (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .o_ref(ref_clk)
  );

  rtos_divsel u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_ovr_en(div_ovr),
    .i_ovr_code(div_field),
    .i_auto_code(i_auto_div),
    .o_code(o_div_code),
    .o_ratio(o_div_ratio)
  );

  // Bus: one wait cycle, then answer
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      bus_state <= RTOS_IDLE;
    else if (i_ce)
      bus_state <= (req && bus_state == RTOS_IDLE) ? RTOS_ACK : RTOS_IDLE;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_avs_readdata <= 32'h0000_0000;
    else if (i_ce && req && bus_state == RTOS_IDLE)
      o_avs_readdata <= {24'h000000, rd_val};
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ovr_reg <= `RTOS_OVR_RST;
      mux_sel <= `RTOS_MUX_RST;
      sd_ctl <= 2'b00;
      div_field <= `RTOS_DIV_RST;
      qclk_en <= 2'b00;
    end
    else if (i_ce && wr0)
    begin
      if (hit_ovr)
        ovr_reg <= i_avs_writedata[7:0];
      if (hit_mux)
        mux_sel <= i_avs_writedata[`RTOS_MUX_LSB+:3];
      if (hit_sd)
        sd_ctl <= i_avs_writedata[`RTOS_SD_KILL_BIT+:2];
      if (hit_div)
        div_field <= i_avs_writedata[`RTOS_DIV_LSB+:3];
      if (hit_qclk)
        qclk_en <= i_avs_writedata[1:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_src <= RTOS_SRC_MUTE;
      o_data <= 1'b0;
      o_drv_en <= 1'b0;
      o_chan_pwr <= 1'b0;
    end
    else if (i_ce)
    begin
      o_src <= next_src;
      o_data <= next_data;
      o_drv_en <= next_src != RTOS_SRC_MUTE;
      o_chan_pwr <= pwr_on;
    end
  end

  // Frozen clock enable must not let a request appear answered
  assign o_avs_waitrequest = req && (bus_state == RTOS_IDLE || !i_ce);
  assign o_avs_response = (acc && !mapped) ? 2'b11 : 2'b00;
endmodule // rtos_top
`default_nettype wire

// ==== verif/rtos_top_props.sv ====
// Port checker for the output select block
`default_nettype none
module rtos_top_props
  import rtos_pkg::*;
(
  input wire logic i_clk_sys, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic i_ce, // Enable
  input wire logic i_retimed_data, // Retimed
  input wire logic i_vco_iclk, // I clock
  input wire logic o_data, // Output bit
  input wire logic o_drv_en, // Driver
  input wire logic o_chan_pwr, // Power
  input wire rtos_src_t o_src, // Source
  input wire logic [2:0] o_div_code, // Code
  input wire logic [4:0] o_div_ratio // Ratio
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  drv_src_a: assert property (o_drv_en == (o_src != RTOS_SRC_MUTE))
    else $error("driver enable and source disagree");
  mute_data_a: assert property (o_src == RTOS_SRC_MUTE |-> !o_data)
    else $error("muted output not low");
  pwr_drv_a: assert property (!o_chan_pwr |-> !o_drv_en)
    else $error("driver on while powered down");
  no_invalid_a: assert property (o_src != RTOS_SRC_INVALID)
    else $error("invalid source applied");
  div_range_a: assert property (o_div_code <= 3'h4)
    else $error("divider code out of range");
  div_ratio_a: assert property (o_div_ratio == (5'h1 << o_div_code))
    else $error("ratio does not match code");
  retimed_a: assert property (o_src == RTOS_SRC_RETIMED && $past(i_ce)
    |-> o_data == $past(i_retimed_data)) else $error("retimed bit wrong");
  iclk_out_a: assert property (o_src == RTOS_SRC_ICLK && $past(i_ce)
    |-> o_data == $past(i_vco_iclk)) else $error("I clock bit wrong");
  cover property (o_src == RTOS_SRC_RETIMED);
  cover property (o_src == RTOS_SRC_REFCLK);
  cover property (o_div_ratio == 5'h10);
endmodule // rtos_top_props
bind rtos_top rtos_top_props rtos_top_props_inst (.i_clk_sys, .i_rst_n,
  .i_ce, .i_retimed_data, .i_vco_iclk, .o_data, .o_drv_en, .o_chan_pwr,
  .o_src, .o_div_code, .o_div_ratio);
`default_nettype wire

// ==== verif/rtos_link_model.sv ====
// Far-side channel model: detect, lock and source bits
`default_nettype none
module rtos_link_model (
  input wire logic i_clk_sys, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic i_present, // Line active
  input wire logic i_lock_ok, // Lockable
  output logic o_sig_det, // Detect
  output var logic o_locked, // Lock
  output logic o_raw, // Raw bit
  output logic o_ret, // Retimed bit
  output logic o_iclk, // I clock
  output logic o_qclk, // Q clock
  output logic o_pat // Pattern bit
);
  logic [3:0] cnt;
  assign o_sig_det = i_present;
  assign o_iclk = cnt[0];
  assign o_qclk = cnt[1];
  assign o_pat = cnt[3] ^ cnt[1];
  // Without a signal data lines carry noise
  assign o_raw = i_present ? cnt[2] : ~cnt[0];
  assign o_ret = i_present ? cnt[3] : cnt[1];
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n)
    begin
      cnt <= 4'h0;
      o_locked <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 4'h1;
      o_locked <= i_present && i_lock_ok;
    end
endmodule // rtos_link_model
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the output select block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rtos_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_ce, i_avs_read, i_avs_write, present, lock_ok;
  logic [3:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  logic [2:0] i_auto_div, o_div_code;
  logic [4:0] o_div_ratio;
  logic [1:0] o_avs_response, rr;
  logic o_avs_waitrequest, sd, lk, rw, rt, ic, qc, pt, o_data, o_drv_en;
  logic o_chan_pwr;
  rtos_src_t o_src;
  logic [7:0] rv;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  rtos_link_model rtos_link_model_inst (.i_clk_sys, .i_rst_n,
    .i_present(present), .i_lock_ok(lock_ok), .o_sig_det(sd),
    .o_locked(lk), .o_raw(rw), .o_ret(rt), .o_iclk(ic), .o_qclk(qc),
    .o_pat(pt));
  rtos_top rtos_top_inst (.i_clk_sys, .i_rst_n, .i_ce, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable(4'hF),
    .o_avs_readdata, .o_avs_waitrequest, .o_avs_response, .i_sig_det(sd),
    .i_locked(lk), .i_raw_data(rw), .i_retimed_data(rt), .i_vco_iclk(ic),
    .i_vco_qclk(qc), .i_pattern(pt), .i_auto_div, .o_data, .o_drv_en,
    .o_chan_pwr, .o_src, .o_div_code, .o_div_ratio);
  always #4 i_clk_sys = ~i_clk_sys;
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge, or for at most 50 edges
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_avs_address <= a;
    i_avs_writedata <= {24'h0, d};
    i_avs_write <= w;
    i_avs_read <= !w;
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end
    while (o_avs_waitrequest !== 1'b0 && n < 50);
    rv = o_avs_readdata[7:0];
    rr = o_avs_response;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task automatic line(input logic p, input logic l);
    @(posedge i_clk_sys);
    present <= p;
    lock_ok <= l;
  endtask
  task automatic out(input logic [2:0] s, input logic p);
    repeat (3) @(negedge i_clk_sys);
    chk("source", 8'(o_src), {5'h0, s});
    chk("power", {7'h0, o_chan_pwr}, {7'h0, p});
    chk("driver", {7'h0, o_drv_en}, {7'h0, s != 3'h7});
  endtask
  task automatic t_regs();
    chk("reset source", 8'(o_src), 8'h07);
    bus(1'b0, 4'h0, 8'h00);
    chk("override reg", rv, 8'h00);
    bus(1'b0, 4'h1, 8'h00);
    chk("selector reg", rv, 8'hE0);
    bus(1'b0, 4'h6, 8'h00);
    chk("unmapped resp", {6'h0, rr}, 8'h03);
  endtask
  task automatic t_default();
    line(1'b0, 1'b0);
    out(3'h7, 1'b0);
    line(1'b1, 1'b0);
    out(3'h7, 1'b1);
    line(1'b1, 1'b1);
    out(3'h1, 1'b1);
    bus(1'b1, 4'h1, 8'h00);
    line(1'b1, 1'b0);
    out(3'h0, 1'b1);
    line(1'b1, 1'b1);
    out(3'h1, 1'b1);
  endtask
  task automatic t_override();
    bus(1'b1, 4'h0, 8'h20);
    for (int k = 0; k < 8; k++)
    begin
      bus(1'b1, 4'h1, 8'(k << 5));
      out((k == 6 || k == 3) ? 3'h7 : 3'(k), 1'b1);
    end
    bus(1'b1, 4'h5, 8'h03);
    bus(1'b1, 4'h1, 8'h60);
    out(3'h3, 1'b1);
  endtask
  task automatic t_force();
    line(1'b0, 1'b0);
    bus(1'b1, 4'h2, 8'h80);
    bus(1'b1, 4'h1, 8'hA0);
    out(3'h5, 1'b1);
    bus(1'b1, 4'h1, 8'h20);
    out(3'h1, 1'b1);
    bus(1'b1, 4'h2, 8'h00);
    out(3'h7, 1'b0);
    bus(1'b1, 4'h1, 8'h00);
    bus(1'b1, 4'h0, 8'hA0);
    out(3'h0, 1'b1);
    bus(1'b1, 4'h0, 8'h00);
    out(3'h7, 1'b0);
  endtask
  task automatic t_div();
    logic [2:0] e;
    @(posedge i_clk_sys);
    i_auto_div <= 3'h3;
    out(3'h7, 1'b0);
    chk("auto ratio", {3'h0, o_div_ratio}, 8'h08);
    bus(1'b1, 4'h0, 8'h04);
    for (int k = 0; k < 6; k++)
    begin
      e = (k > 4) ? 3'h4 : 3'(k);
      bus(1'b1, 4'h3, 8'(k << 4));
      out(3'h7, 1'b0);
      chk("div code", {5'h0, o_div_code}, {5'h0, e});
      chk("div ratio", {3'h0, o_div_ratio}, 8'(1 << e));
    end
    bus(1'b1, 4'h0, 8'h00);
    out(3'h7, 1'b0);
    chk("restored code", {5'h0, o_div_code}, 8'h03);
  endtask
  initial
  begin
    i_ce = 1'b1;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 4'h0;
    i_avs_writedata = 32'h0;
    i_auto_div = 3'h0;
    present = 1'b0;
    lock_ok = 1'b0;
    repeat (6) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(negedge i_clk_sys);
    t_regs();
    t_default();
    t_override();
    t_force();
    t_div();
    final_report();
  end
endmodule // testbench
`default_nettype wire
